// ==== common/reprog_pkg.sv ====
// constants, register map and carrier types for the serial flash reprogram interpreter
package reprog_pkg;

	// ----------------------------------------
	// serial command and answer codes
	// ----------------------------------------
	localparam logic [7:0] CMD_PROG_ERASE = 8'h50;
	localparam logic [7:0] CMD_READ_FLASH = 8'h52;
	localparam logic [7:0] SUCCESS_CODE = 8'h00;
	localparam logic [7:0] FAILURE_CODE = 8'h01;
	localparam logic [7:0] TRANSFER_REQUEST_CODE = 8'h11;
	localparam logic [7:0] PAD_BYTE = 8'hff;

	// ----------------------------------------
	// flash geometry and accepted address windows
	// ----------------------------------------
	localparam logic [4:0] FIRST_WRITABLE_BLOCK = 5'h01;
	localparam logic [4:0] LAST_WRITABLE_BLOCK = 5'h13;
	localparam logic [31:0] PROG_ADDR_MIN = 32'h0000_2000;
	localparam logic [31:0] PROG_ADDR_MAX = 32'h000f_ffff;
	localparam logic [31:0] READ_ADDR_MAX = 32'h000f_ffff;
	localparam logic [31:0] PAGE_BYTES = 32'h0000_0100;
	localparam logic [7:0] PAGE_LAST_IDX = 8'hff;
	localparam logic [2:0] HDR_LAST_IDX = 3'h7;
	localparam logic [2:0] ADDR_LAST_IDX = 3'h3;

	// ----------------------------------------
	// register map and reset values
	// ----------------------------------------
	localparam logic [31:0] PORT_A_LOW_FUNCTION_SELECT_2_OFS = 32'hfffe_3814;
	localparam logic [31:0] PORT_A_LOW_FUNCTION_SELECT_1_OFS = 32'hfffe_3816;
	localparam logic [31:0] SERIAL_FRAME_MODE_OFS = 32'hffff_8000;
	localparam logic [31:0] SERIAL_BAUD_DIVISOR_OFS = 32'hffff_8802;
	localparam logic [31:0] SERIAL_CONTROL_OFS = 32'hffff_8804;
	localparam logic [31:0] EVENT_STATUS_OFS = 32'hffff_8810;
	localparam logic [31:0] EVENT_MASK_OFS = 32'hffff_8814;
	localparam logic [31:0] ENGINE_STATE_OFS = 32'hffff_8818;
	localparam logic [15:0] PORT_A_SEL2_RST = 16'h0006;
	localparam logic [15:0] PORT_A_SEL1_RST = 16'h6000;
	localparam logic [7:0] FRAME_MODE_RST = 8'h00;
	localparam logic [7:0] BAUD_DIV_RST = 8'ha2;
	localparam logic [7:0] SERIAL_CTRL_RST = 8'h30;
	localparam int TRANSMITTER_ENABLE_BIT = 5;
	localparam int RECEIVER_ENABLE_BIT = 4;

	// event bits: status and mask share this layout
	localparam int EV_W = 3;
	localparam int EV_DONE_OK = 0;
	localparam int EV_FAIL = 1;
	localparam int EV_CMD = 2;

	// ----------------------------------------
	// timing: divisor step as the serial block sees it
	// ----------------------------------------
	localparam int BAUD_BPS = 9600;
	localparam int PERIPH_CLK_HZ = 50_000_000;
	localparam int SYS_CLK_HZ = 200_000_000;
	localparam int SCI_DIV_SCALE = 32;
	localparam int DIV_STEP_CYCLES_DOC = SCI_DIV_SCALE * (SYS_CLK_HZ / PERIPH_CLK_HZ);
	localparam int SERIAL_BITS = 9;

	// ----------------------------------------
	// carriers
	// ----------------------------------------
	typedef struct packed {
		logic [31:0] addr;
		logic [15:0] wdata;
		logic wr;
		logic rd;
	} reg_req_s;

	typedef struct packed {
		logic erase;
		logic prog;
		logic read;
		logic [4:0] block;
		logic [31:0] addr;
	} flash_cmd_s;

endpackage

// ==== src/serial_flash_reprogram_cmd.sv ====
// serial command interpreter that erases, programs and reads back the user flash area
// ----------------------------------------
// What this block does
// R1 - wait until flash write-enable pin permits
// R2 - then send transfer request code
// R3 - 0x50 selects erase then program
// R4 - 0x52 selects flash read
// R5 - answers: 0x00 ok, 0x01 error, 0x11 request
// R6 - erase blocks one to last, then request
// R7 - take address and length, then request
// R8 - program start address window check, else halt
// R9 - boot block zero never erased or programmed
// R10 - request after every 256-byte chunk but the last
// R11 - one program per chunk, pad with 0xff
// R12 - success code when length reached
// R13 - erase or program failure sends error then halts
// R14 - read: request, header, stream bytes back
// R15 - read start address window check, else halt
// R16 - 9600 bps from divisor 162
// R17 - 8 data bits, no parity, one stop
// R18 - address and length sent msb first
// R19 - unknown command bytes silently ignored
// ----------------------------------------
module serial_flash_reprogram_cmd #(
	parameter int DIV_STEP_CYCLES = reprog_pkg::DIV_STEP_CYCLES_DOC
) (
	input wire logic sys_clk_i,
	input wire logic srst_i,
	input wire logic ce_i,
	input wire reprog_pkg::reg_req_s reg_req_i,
	output logic [15:0] reg_rdata_o,
	output logic irq_o,
	input wire logic flash_write_enable_pin_state_i,
	input wire logic serial_rx_pin_i,
	output logic serial_tx_pin_o,
	output reprog_pkg::flash_cmd_s flash_cmd_o,
	input wire logic flash_done_i,
	input wire logic flash_err_i,
	input wire logic [7:0] flash_rd_data_i,
	input wire logic [7:0] page_idx_i,
	output logic [7:0] page_data_o
);
	import reprog_pkg::*;

	typedef enum logic [3:0] {
		ST_PINWAIT = 4'h0, ST_SEND = 4'h1, ST_CMD = 4'h3, ST_ERASE = 4'h2,
		ST_ERWAIT = 4'h6, ST_HDR = 4'h7, ST_FILL = 4'h5, ST_PAD = 4'h4,
		ST_PROG = 4'hc, ST_PGWAIT = 4'hd, ST_RDREQ = 4'hf, ST_RDWAIT = 4'he,
		ST_HALT = 4'ha
	} state_e;

	// ----------------------------------------
	// register file
	// ----------------------------------------
	logic [15:0] sel2_r, sel2_nxt, sel1_r, sel1_nxt, rdata_r, rdata_nxt;
	logic [7:0] mode_r, mode_nxt, baud_r, baud_nxt, ctrl_r, ctrl_nxt;
	logic [EV_W-1:0] ev_r, ev_nxt, mask_r, mask_nxt, ev_set;
	state_e st_r, st_nxt, ret_r, ret_nxt;

	always_comb begin
		sel2_nxt = sel2_r;
		sel1_nxt = sel1_r;
		mode_nxt = mode_r;
		baud_nxt = baud_r;
		ctrl_nxt = ctrl_r;
		mask_nxt = mask_r;
		ev_nxt = ev_r;
		rdata_nxt = 16'h0;
		if (reg_req_i.wr) begin
			case (reg_req_i.addr)
				PORT_A_LOW_FUNCTION_SELECT_2_OFS: sel2_nxt = reg_req_i.wdata;
				PORT_A_LOW_FUNCTION_SELECT_1_OFS: sel1_nxt = reg_req_i.wdata;
				SERIAL_FRAME_MODE_OFS: mode_nxt = reg_req_i.wdata[7:0];
				SERIAL_BAUD_DIVISOR_OFS: baud_nxt = reg_req_i.wdata[7:0];
				SERIAL_CONTROL_OFS: ctrl_nxt = reg_req_i.wdata[7:0];
				EVENT_MASK_OFS: mask_nxt = reg_req_i.wdata[EV_W-1:0];
				EVENT_STATUS_OFS: ev_nxt = ev_r & ~reg_req_i.wdata[EV_W-1:0];
				default: ;
			endcase
		end
		// a new event beats a write-one-to-clear in the same cycle
		ev_nxt = ev_nxt | ev_set;
		if (reg_req_i.rd) begin
			case (reg_req_i.addr)
				PORT_A_LOW_FUNCTION_SELECT_2_OFS: rdata_nxt = sel2_r;
				PORT_A_LOW_FUNCTION_SELECT_1_OFS: rdata_nxt = sel1_r;
				SERIAL_FRAME_MODE_OFS: rdata_nxt = {8'h0, mode_r};
				SERIAL_BAUD_DIVISOR_OFS: rdata_nxt = {8'h0, baud_r};
				SERIAL_CONTROL_OFS: rdata_nxt = {8'h0, ctrl_r};
				EVENT_STATUS_OFS: rdata_nxt = {13'h0, ev_r};
				EVENT_MASK_OFS: rdata_nxt = {13'h0, mask_r};
				ENGINE_STATE_OFS: rdata_nxt = {11'h0, flash_write_enable_pin_state_i, st_r};
				default: rdata_nxt = 16'h0;
			endcase
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			sel2_r <= PORT_A_SEL2_RST;
			sel1_r <= PORT_A_SEL1_RST;
			mode_r <= FRAME_MODE_RST; // R17
			baud_r <= BAUD_DIV_RST; // R16
			ctrl_r <= SERIAL_CTRL_RST; // R17
			mask_r <= '0;
			ev_r <= '0;
			rdata_r <= 16'h0;
		end else if (ce_i) begin
			sel2_r <= sel2_nxt;
			sel1_r <= sel1_nxt;
			mode_r <= mode_nxt;
			baud_r <= baud_nxt;
			ctrl_r <= ctrl_nxt;
			mask_r <= mask_nxt;
			ev_r <= ev_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	assign reg_rdata_o = rdata_r;
	assign irq_o = |(ev_r & mask_r);

	// ----------------------------------------
	// serial line, 8 data bits lsb first, no parity, one stop
	// ----------------------------------------
	logic [31:0] bit_len, rx_cnt_r, rx_cnt_nxt, tx_cnt_r, tx_cnt_nxt;
	logic [3:0] rx_bit_r, rx_bit_nxt, tx_bit_r, tx_bit_nxt;
	logic [7:0] rx_sh_r, rx_sh_nxt, rx_byte_r, rx_byte_nxt, tx_code_r, tx_code_nxt;
	logic [9:0] tx_sh_r, tx_sh_nxt;
	logic rx_act_r, rx_act_nxt, rx_vld_r, rx_vld_nxt, tx_busy_r, tx_busy_nxt, tx_start;

	// the divisor register sets the bit time, so software retunes the rate
	assign bit_len = 32'(({24'h0, baud_r} + 32'h1) * DIV_STEP_CYCLES); // R16

	always_comb begin
		rx_cnt_nxt = rx_cnt_r;
		rx_bit_nxt = rx_bit_r;
		rx_sh_nxt = rx_sh_r;
		rx_act_nxt = rx_act_r;
		rx_byte_nxt = rx_byte_r;
		rx_vld_nxt = 1'b0;
		if (!rx_act_r) begin
			if (ctrl_r[RECEIVER_ENABLE_BIT] && !serial_rx_pin_i) begin
				rx_act_nxt = 1'b1;
				rx_bit_nxt = 4'h0;
				rx_cnt_nxt = bit_len >> 1;
			end
		end else if (rx_cnt_r != 32'h0) begin
			rx_cnt_nxt = rx_cnt_r - 32'h1;
		end else begin
			rx_cnt_nxt = bit_len - 32'h1;
			rx_bit_nxt = 4'(rx_bit_r + 4'h1);
			if (rx_bit_r == 4'h0) begin
				// a glitch shorter than half a bit is not a start bit
				rx_act_nxt = !serial_rx_pin_i;
			end else if (rx_bit_r < 4'(SERIAL_BITS)) begin
				rx_sh_nxt = {serial_rx_pin_i, rx_sh_r[7:1]}; // R17
			end else begin
				rx_act_nxt = 1'b0;
				rx_vld_nxt = serial_rx_pin_i;
				rx_byte_nxt = rx_sh_r;
			end
		end
		tx_cnt_nxt = tx_cnt_r;
		tx_bit_nxt = tx_bit_r;
		tx_sh_nxt = tx_sh_r;
		tx_busy_nxt = tx_busy_r;
		if (tx_start) begin
			tx_sh_nxt = {1'b1, tx_code_nxt, 1'b0}; // R17
			tx_busy_nxt = 1'b1;
			tx_bit_nxt = 4'h0;
			tx_cnt_nxt = bit_len - 32'h1;
		end else if (tx_busy_r) begin
			if (tx_cnt_r != 32'h0) begin
				tx_cnt_nxt = tx_cnt_r - 32'h1;
			end else begin
				tx_cnt_nxt = bit_len - 32'h1;
				tx_sh_nxt = {1'b1, tx_sh_r[9:1]};
				tx_bit_nxt = 4'(tx_bit_r + 4'h1);
				tx_busy_nxt = tx_bit_r != 4'(SERIAL_BITS);
			end
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			rx_cnt_r <= 32'h0;
			rx_bit_r <= 4'h0;
			rx_sh_r <= 8'h0;
			rx_act_r <= 1'b0;
			rx_byte_r <= 8'h0;
			rx_vld_r <= 1'b0;
			tx_cnt_r <= 32'h0;
			tx_bit_r <= 4'h0;
			tx_sh_r <= 10'h3ff;
			tx_busy_r <= 1'b0;
		end else if (ce_i) begin
			rx_cnt_r <= rx_cnt_nxt;
			rx_bit_r <= rx_bit_nxt;
			rx_sh_r <= rx_sh_nxt;
			rx_act_r <= rx_act_nxt;
			rx_byte_r <= rx_byte_nxt;
			rx_vld_r <= rx_vld_nxt;
			tx_cnt_r <= tx_cnt_nxt;
			tx_bit_r <= tx_bit_nxt;
			tx_sh_r <= tx_sh_nxt;
			tx_busy_r <= tx_busy_nxt;
		end
	end

	assign serial_tx_pin_o = tx_sh_r[0];

	// ----------------------------------------
	// command engine
	// ----------------------------------------
	logic [7:0] page_buf [0:255];
	logic [7:0] fill_r, fill_nxt, buf_wdata, page_data_r;
	logic [31:0] addr_r, addr_nxt, len_r, len_nxt, len_in;
	logic [4:0] blk_r, blk_nxt;
	logic [2:0] hdr_r, hdr_nxt;
	logic wr_mode_r, wr_mode_nxt, buf_we;
	flash_cmd_s cmd_r, cmd_nxt;

	assign len_in = {len_r[23:0], rx_byte_r}; // R18

	always_comb begin
		st_nxt = st_r;
		ret_nxt = ret_r;
		tx_code_nxt = tx_code_r;
		tx_start = 1'b0;
		fill_nxt = fill_r;
		addr_nxt = addr_r;
		len_nxt = len_r;
		blk_nxt = blk_r;
		hdr_nxt = hdr_r;
		wr_mode_nxt = wr_mode_r;
		cmd_nxt = '0;
		buf_we = 1'b0;
		buf_wdata = rx_byte_r;
		ev_set = '0;
		case (st_r)
			ST_PINWAIT: begin
				if (flash_write_enable_pin_state_i) begin // R1
					tx_code_nxt = TRANSFER_REQUEST_CODE; // R2
					ret_nxt = ST_CMD;
					st_nxt = ST_SEND;
				end
			end
			ST_SEND: begin
				if (ctrl_r[TRANSMITTER_ENABLE_BIT] && !tx_busy_r) begin
					tx_start = 1'b1;
					st_nxt = ret_r;
				end
			end
			ST_CMD: begin
				hdr_nxt = 3'h0;
				if (rx_vld_r && rx_byte_r == CMD_PROG_ERASE) begin // R3
					ev_set[EV_CMD] = 1'b1;
					wr_mode_nxt = 1'b1;
					blk_nxt = FIRST_WRITABLE_BLOCK; // R9
					st_nxt = ST_ERASE;
				end else if (rx_vld_r && rx_byte_r == CMD_READ_FLASH) begin // R4
					ev_set[EV_CMD] = 1'b1;
					wr_mode_nxt = 1'b0;
					tx_code_nxt = TRANSFER_REQUEST_CODE; // R14
					ret_nxt = ST_HDR;
					st_nxt = ST_SEND;
				end
				// any other byte falls through and is dropped R19
			end
			ST_ERASE: begin
				cmd_nxt.erase = 1'b1; // R6
				cmd_nxt.block = blk_r;
				st_nxt = ST_ERWAIT;
			end
			ST_ERWAIT: begin
				if (flash_err_i) begin
					ev_set[EV_FAIL] = 1'b1;
					tx_code_nxt = FAILURE_CODE; // R13
					ret_nxt = ST_HALT;
					st_nxt = ST_SEND;
				end else if (flash_done_i && blk_r == LAST_WRITABLE_BLOCK) begin
					tx_code_nxt = TRANSFER_REQUEST_CODE; // R6
					ret_nxt = ST_HDR;
					st_nxt = ST_SEND;
				end else if (flash_done_i) begin
					blk_nxt = 5'(blk_r + 5'h1);
					st_nxt = ST_ERASE;
				end
			end
			ST_HDR: begin
				if (rx_vld_r) begin
					hdr_nxt = 3'(hdr_r + 3'h1);
					if (hdr_r <= ADDR_LAST_IDX) begin
						addr_nxt = {addr_r[23:0], rx_byte_r}; // R18
					end else begin
						len_nxt = len_in; // R7
					end
					fill_nxt = 8'h0;
					if (hdr_r == HDR_LAST_IDX) begin
						st_nxt = ST_SEND;
						if (wr_mode_r && (addr_r < PROG_ADDR_MIN || addr_r > PROG_ADDR_MAX)) begin
							ev_set[EV_FAIL] = 1'b1; // R8
							tx_code_nxt = FAILURE_CODE;
							ret_nxt = ST_HALT;
						end else if (!wr_mode_r && addr_r > READ_ADDR_MAX) begin
							ev_set[EV_FAIL] = 1'b1; // R15
							tx_code_nxt = FAILURE_CODE;
							ret_nxt = ST_HALT;
						end else if (len_in == 32'h0) begin
							ev_set[EV_DONE_OK] = wr_mode_r;
							tx_code_nxt = SUCCESS_CODE; // R5
							ret_nxt = ST_CMD;
							st_nxt = wr_mode_r ? ST_SEND : ST_CMD;
						end else if (wr_mode_r) begin
							tx_code_nxt = TRANSFER_REQUEST_CODE; // R7
							ret_nxt = ST_FILL;
						end else begin
							st_nxt = ST_RDREQ; // R14
						end
					end
				end
			end
			ST_FILL: begin
				if (rx_vld_r) begin
					buf_we = 1'b1;
					fill_nxt = 8'(fill_r + 8'h1);
					len_nxt = len_r - 32'h1;
					if (fill_r == PAGE_LAST_IDX) begin
						st_nxt = ST_PROG; // R10
					end else if (len_r == 32'h1) begin
						st_nxt = ST_PAD; // R11
					end
				end
			end
			ST_PAD: begin
				buf_we = 1'b1;
				buf_wdata = PAD_BYTE; // R11
				fill_nxt = 8'(fill_r + 8'h1);
				if (fill_r == PAGE_LAST_IDX) begin
					st_nxt = ST_PROG;
				end
			end
			ST_PROG: begin
				cmd_nxt.prog = 1'b1; // R11
				cmd_nxt.addr = addr_r;
				st_nxt = ST_PGWAIT;
			end
			ST_PGWAIT: begin
				st_nxt = (flash_err_i || flash_done_i) ? ST_SEND : ST_PGWAIT;
				if (flash_err_i) begin
					ev_set[EV_FAIL] = 1'b1;
					tx_code_nxt = FAILURE_CODE; // R13
					ret_nxt = ST_HALT;
				end else if (flash_done_i) begin
					addr_nxt = addr_r + PAGE_BYTES;
					fill_nxt = 8'h0;
					if (len_r == 32'h0) begin
						ev_set[EV_DONE_OK] = 1'b1;
						tx_code_nxt = SUCCESS_CODE; // R12
						ret_nxt = ST_CMD;
					end else begin
						tx_code_nxt = TRANSFER_REQUEST_CODE; // R10
						ret_nxt = ST_FILL;
					end
				end
			end
			ST_RDREQ: begin
				cmd_nxt.read = 1'b1; // R14
				cmd_nxt.addr = addr_r;
				st_nxt = ST_RDWAIT;
			end
			ST_RDWAIT: begin
				if (flash_done_i) begin
					tx_code_nxt = flash_rd_data_i;
					addr_nxt = addr_r + 32'h1;
					len_nxt = len_r - 32'h1;
					ret_nxt = (len_r == 32'h1) ? ST_CMD : ST_RDREQ;
					st_nxt = ST_SEND;
				end
			end
			ST_HALT: st_nxt = ST_HALT; // R13
			default: st_nxt = ST_HALT;
		endcase
	end

	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			st_r <= ST_PINWAIT;
			ret_r <= ST_CMD;
			tx_code_r <= 8'h0;
			fill_r <= 8'h0;
			addr_r <= 32'h0;
			len_r <= 32'h0;
			blk_r <= FIRST_WRITABLE_BLOCK;
			hdr_r <= 3'h0;
			wr_mode_r <= 1'b0;
			cmd_r <= '0;
			page_data_r <= 8'h0;
		end else if (ce_i) begin
			st_r <= st_nxt;
			ret_r <= ret_nxt;
			tx_code_r <= tx_code_nxt;
			fill_r <= fill_nxt;
			addr_r <= addr_nxt;
			len_r <= len_nxt;
			blk_r <= blk_nxt;
			hdr_r <= hdr_nxt;
			wr_mode_r <= wr_mode_nxt;
			cmd_r <= cmd_nxt;
			page_data_r <= page_buf[page_idx_i];
		end
	end

	// page buffer holds no reset; every byte is rewritten before each program
	always_ff @(posedge sys_clk_i) begin
		if (ce_i && buf_we) begin
			page_buf[fill_r] <= buf_wdata;
		end
	end

	assign flash_cmd_o = cmd_r;
	assign page_data_o = page_data_r;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (srst_i || !ce_i);

	sequence s_cmd_byte(logic [7:0] code);
		st_r == ST_CMD && rx_vld_r && rx_byte_r == code;
	endsequence
	sequence s_req_queued(state_e nxt);
		st_r == ST_SEND && tx_code_r == TRANSFER_REQUEST_CODE && ret_r == nxt;
	endsequence

	a_pin_wait_hold: assert property ((st_r == ST_PINWAIT && !flash_write_enable_pin_state_i)
		|=> st_r == ST_PINWAIT) else $error("left pin wait too early"); // R1
	a_pin_request: assert property ((st_r == ST_PINWAIT && flash_write_enable_pin_state_i)
		|=> s_req_queued(ST_CMD)) else $error("no request after pin enable"); // R2
	a_prog_erase_start: assert property (s_cmd_byte(CMD_PROG_ERASE) |=> st_r == ST_ERASE
		##1 (cmd_r.erase && cmd_r.block == FIRST_WRITABLE_BLOCK))
		else $error("erase did not start at block one"); // R3
	a_read_cmd_req: assert property (s_cmd_byte(CMD_READ_FLASH) |=> s_req_queued(ST_HDR))
		else $error("read command not answered by request"); // R4
	a_unknown_ignored: assert property ((st_r == ST_CMD && rx_vld_r
		&& rx_byte_r != CMD_PROG_ERASE && rx_byte_r != CMD_READ_FLASH)
		|=> st_r == ST_CMD && $stable(ev_r)) else $error("stray byte acted on"); // R19
	a_boot_block_safe: assert property (cmd_r.erase |-> cmd_r.block >= FIRST_WRITABLE_BLOCK
		&& cmd_r.block <= LAST_WRITABLE_BLOCK) else $error("erase outside writable"); // R9
	a_prog_addr_window: assert property (cmd_r.prog |-> cmd_r.addr >= PROG_ADDR_MIN)
		else $error("program below writable area"); // R8
	a_pad_value: assert property (st_r == ST_PAD |=> page_buf[$past(fill_r)] == PAD_BYTE)
		else $error("pad byte not 0xff"); // R11
	a_chunk_to_prog: assert property ((st_r == ST_FILL && rx_vld_r && fill_r == PAGE_LAST_IDX)
		|=> st_r == ST_PROG ##1 cmd_r.prog) else $error("full chunk not programmed"); // R10
	a_fail_halts: assert property ((st_r == ST_PGWAIT && flash_err_i)
		|=> st_r == ST_SEND && tx_code_r == FAILURE_CODE && ret_r == ST_HALT)
		else $error("program failure not reported"); // R13
	a_halt_sticky: assert property (st_r == ST_HALT |=> (st_r == ST_HALT) [*4])
		else $error("halt left"); // R13
	a_read_window: assert property ((st_r == ST_HDR && rx_vld_r && hdr_r == HDR_LAST_IDX
		&& !wr_mode_r && addr_r > READ_ADDR_MAX) |=> tx_code_r == FAILURE_CODE
		&& ret_r == ST_HALT) else $error("bad read address accepted"); // R15

endmodule

// ==== tb/host_uart_model.sv ====
// host computer model: 8n1 serial framing on both lines of the link
module host_uart_model (
	input wire logic sys_clk_i,
	input wire logic [31:0] bit_cyc_i,
	input wire logic dev_tx_i,
	output logic dev_rx_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// idle line rests high between frames
	initial dev_rx_o = 1'b1;

	// start bit, 8 data bits lsb first, one stop bit, no parity
	task automatic send_byte(input logic [7:0] b);
		logic [9:0] f;
		f = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++) begin
			@(posedge sys_clk_i);
			dev_rx_o <= f[i];
			repeat (bit_cyc_i - 1) @(posedge sys_clk_i);
		end
	endtask

	// samples on the falling clock edge so the registered tx pin has settled
	task automatic recv_byte(input int limit, output logic [7:0] b, output logic ok);
		int n;
		n = 0;
		ok = 1'b0;
		b = 8'h00;
		while (dev_tx_i !== 1'b0 && n < limit) begin
			@(negedge sys_clk_i);
			n++;
		end
		if (n >= limit) return;
		repeat (bit_cyc_i / 2) @(negedge sys_clk_i);
		for (int i = 0; i < 8; i++) begin
			repeat (bit_cyc_i) @(negedge sys_clk_i);
			b[i] = dev_tx_i;
		end
		repeat (bit_cyc_i) @(negedge sys_clk_i);
		ok = (dev_tx_i === 1'b1);
	endtask
endmodule

// ==== tb/serial_flash_reprogram_cmd_tb.sv ====
// self-checking bench for the serial flash reprogram interpreter
module serial_flash_reprogram_cmd_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import reprog_pkg::*;

	logic sys_clk_i = 1'b0;
	logic srst_i = 1'b1;
	reg_req_s req = '0;
	logic [15:0] rdata;
	logic irq;
	logic pin = 1'b0;
	logic rx_line;
	logic tx_line;
	flash_cmd_s fcmd;
	logic fdone = 1'b0;
	logic ferr = 1'b0;
	logic [7:0] frd = 8'h00;
	logic [7:0] pidx = 8'h00;
	logic [7:0] pdata;
	int bit_cyc = 163;
	int err_count = 0;
	int tests_run = 0;
	logic [4:0] fail_blk = 5'h00;
	logic fail_prog = 1'b0;
	logic [4:0] erased[$];
	logic [31:0] progs[$];
	int rd_cnt = 0;
	logic [7:0] page[256];

	always #2.5 sys_clk_i = ~sys_clk_i;

	serial_flash_reprogram_cmd #(.DIV_STEP_CYCLES(1)) dut_u (
		.sys_clk_i(sys_clk_i), .srst_i(srst_i), .ce_i(1'b1), .reg_req_i(req),
		.reg_rdata_o(rdata), .irq_o(irq), .flash_write_enable_pin_state_i(pin),
		.serial_rx_pin_i(rx_line), .serial_tx_pin_o(tx_line), .flash_cmd_o(fcmd),
		.flash_done_i(fdone), .flash_err_i(ferr), .flash_rd_data_i(frd),
		.page_idx_i(pidx), .page_data_o(pdata)
	);

	host_uart_model host_u (
		.sys_clk_i(sys_clk_i), .bit_cyc_i(bit_cyc), .dev_tx_i(tx_line), .dev_rx_o(rx_line)
	);

	// ----------------------------------------
	// flash sequencer stand-in: one answer per command, a few cycles late, or after the 258-cycle page readout for a program
	// ----------------------------------------
	initial begin
		forever begin
			@(posedge sys_clk_i);
			if (fcmd.erase === 1'b1) begin
				erased.push_back(fcmd.block);
				repeat (2) @(posedge sys_clk_i);
				// the command pulse is gone by now, so judge the block that was logged
				ferr <= (erased[$] == fail_blk);
				fdone <= (erased[$] != fail_blk);
				@(posedge sys_clk_i);
				{ferr, fdone} <= 2'b00;
			end else if (fcmd.prog === 1'b1) begin
				progs.push_back(fcmd.addr);
				// page buffer answers two edges after the index is set
				for (int i = 0; i < 258; i++) begin
					if (i >= 2) page[i - 2] = pdata;
					pidx <= i[7:0];
					@(posedge sys_clk_i);
				end
				ferr <= fail_prog;
				fdone <= !fail_prog;
				@(posedge sys_clk_i);
				{ferr, fdone} <= 2'b00;
			end else if (fcmd.read === 1'b1) begin
				rd_cnt++;
				frd <= fcmd.addr[7:0] ^ 8'h3c;
				fdone <= 1'b1;
				@(posedge sys_clk_i);
				fdone <= 1'b0;
			end
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
			err_count++;
		end
	endtask

	task automatic reg_wr(input logic [31:0] a, input logic [15:0] d);
		@(posedge sys_clk_i);
		req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge sys_clk_i);
		req <= '0;
	endtask

	task automatic rd_chk(input logic [31:0] a, input logic [15:0] exp);
		@(posedge sys_clk_i);
		req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
		@(posedge sys_clk_i);
		req <= '0;
		#1 chk(rdata, exp);
	endtask

	task automatic expect_byte(input int limit, input logic [7:0] exp);
		logic [7:0] b;
		logic ok;
		host_u.recv_byte(limit, b, ok);
		chk({ok, b}, {1'b1, exp});
	endtask

	task automatic expect_quiet(input int limit);
		logic [7:0] b;
		logic ok;
		host_u.recv_byte(limit, b, ok);
		chk(ok, 1'b0);
	endtask

	task automatic send_word(input logic [31:0] w);
		for (int i = 3; i >= 0; i--) host_u.send_byte(w[8 * i +: 8]);
	endtask

	task automatic send_page;
		for (int i = 0; i < 256; i++) host_u.send_byte(8'h80 | i[6:0]);
	endtask

	// restart with a short bit time so long transfers stay cheap
	task automatic restart;
		@(posedge sys_clk_i);
		pin <= 1'b0;
		srst_i <= 1'b1;
		repeat (3) @(posedge sys_clk_i);
		srst_i <= 1'b0;
		erased.delete();
		progs.delete();
		rd_cnt = 0;
		reg_wr(SERIAL_BAUD_DIVISOR_OFS, 16'h0003);
		bit_cyc = 4;
		pin <= 1'b1;
		expect_byte(400, TRANSFER_REQUEST_CODE);
	endtask

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_regs;
		rd_chk(SERIAL_BAUD_DIVISOR_OFS, 16'h00a2);
		rd_chk(SERIAL_FRAME_MODE_OFS, 16'h0000);
		rd_chk(SERIAL_CONTROL_OFS, 16'h0030);
		rd_chk(PORT_A_LOW_FUNCTION_SELECT_2_OFS, 16'h0006);
		rd_chk(PORT_A_LOW_FUNCTION_SELECT_1_OFS, 16'h6000);
		rd_chk(EVENT_STATUS_OFS, 16'h0000);
		rd_chk(32'hffff_8806, 16'h0000);
	endtask

	task automatic t_pin_wait;
		expect_quiet(3000);
		@(posedge sys_clk_i);
		pin <= 1'b1;
		expect_byte(400, TRANSFER_REQUEST_CODE);
		reg_wr(SERIAL_BAUD_DIVISOR_OFS, 16'h0003);
		bit_cyc = 4;
		host_u.send_byte(8'h33);
		expect_quiet(800);
	endtask

	task automatic t_program;
		reg_wr(EVENT_MASK_OFS, 16'h0001);
		rd_chk(EVENT_MASK_OFS, 16'h0001);
		host_u.send_byte(CMD_PROG_ERASE);
		expect_byte(4000, TRANSFER_REQUEST_CODE);
		chk(erased.size(), 19);
		foreach (erased[k]) chk(erased[k], FIRST_WRITABLE_BLOCK + k);
		send_word(PROG_ADDR_MIN);
		send_word(32'h0000_0104);
		expect_byte(400, TRANSFER_REQUEST_CODE);
		send_page();
		expect_byte(2000, TRANSFER_REQUEST_CODE);
		fork
			send_page();
			expect_byte(20000, SUCCESS_CODE);
		join
		chk(progs.size(), 2);
		chk(progs[0], PROG_ADDR_MIN);
		chk(progs[1], PROG_ADDR_MIN + PAGE_BYTES);
		for (int i = 0; i < 256; i++) chk(page[i], i < 4 ? 8'h80 | i[6:0] : PAD_BYTE);
		#1 chk(irq, 1'b1);
		rd_chk(EVENT_STATUS_OFS, 16'h0005);
		reg_wr(EVENT_STATUS_OFS, 16'h0007);
		#1 chk(irq, 1'b0);
	endtask

	task automatic t_erase_fail;
		restart();
		fail_blk = 5'h05;
		host_u.send_byte(CMD_PROG_ERASE);
		expect_byte(4000, FAILURE_CODE);
		chk(erased.size(), 5);
		rd_chk(EVENT_STATUS_OFS, 16'h0006);
		fail_blk = 5'h00;
		host_u.send_byte(CMD_READ_FLASH);
		expect_quiet(800);
	endtask

	task automatic t_bad_prog;
		restart();
		host_u.send_byte(CMD_PROG_ERASE);
		expect_byte(4000, TRANSFER_REQUEST_CODE);
		send_word(32'h0000_1fff);
		send_word(32'h0000_0010);
		expect_byte(400, FAILURE_CODE);
		repeat (300) @(posedge sys_clk_i);
		chk(progs.size(), 0);
	endtask

	// a failed page program must end in the error code and a dead engine
	task automatic t_prog_fail;
		restart();
		fail_prog = 1'b1;
		host_u.send_byte(CMD_PROG_ERASE);
		expect_byte(4000, TRANSFER_REQUEST_CODE);
		send_word(PROG_ADDR_MAX - 32'h0000_00ff);
		send_word(32'h0000_0001);
		expect_byte(400, TRANSFER_REQUEST_CODE);
		fork
			send_page();
			expect_byte(2000, FAILURE_CODE);
		join
		fail_prog = 1'b0;
		chk(progs.size(), 1);
		host_u.send_byte(CMD_READ_FLASH);
		expect_quiet(800);
	endtask

	task automatic t_read;
		restart();
		host_u.send_byte(CMD_READ_FLASH);
		expect_byte(400, TRANSFER_REQUEST_CODE);
		send_word(READ_ADDR_MAX - 32'h1);
		send_word(32'h0000_0002);
		expect_byte(400, 8'hfe ^ 8'h3c);
		expect_byte(400, 8'hff ^ 8'h3c);
		chk(rd_cnt, 2);
		host_u.send_byte(CMD_READ_FLASH);
		expect_byte(400, TRANSFER_REQUEST_CODE);
		send_word(32'h0010_0000);
		send_word(32'h0000_0001);
		expect_byte(400, FAILURE_CODE);
		chk(rd_cnt, 2);
		host_u.send_byte(CMD_PROG_ERASE);
		expect_quiet(800);
	endtask

	task automatic final_report;
		$display("comparisons %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	initial begin
		#(5ns * 60000);
		err_count++;
		final_report();
	end

	initial begin
		repeat (3) @(posedge sys_clk_i);
		srst_i <= 1'b0;
		t_regs();
		t_pin_wait();
		t_program();
		t_erase_fail();
		t_bad_prog();
		t_prog_fail();
		t_read();
		final_report();
	end
endmodule
